// ---- hw/iebk_pkg.sv ----
// Constants shared by the interrupt enable bank: register offsets,
// field positions, reset values and source indices.
// Assumes an 8-bit register port with byte-wide registers.
`default_nettype none

package iebk_pkg;

    // Register port widths.
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets on the register port.
    localparam logic [ADDR_W-1:0] PRI_EN_ADDR = 8'ha8;
    localparam logic [ADDR_W-1:0] SEC_EN_ADDR = 8'ha9;
    localparam logic [ADDR_W-1:0] WAKE_STAT_ADDR = 8'hf0;
    localparam logic [ADDR_W-1:0] WAKE_MASK_ADDR = 8'hf1;

    // Reset values and writable bit masks.
    localparam logic [DATA_W-1:0] REG_RST = 8'h00;
    localparam logic [DATA_W-1:0] PRI_WR_MASK = 8'hbf;
    localparam logic [DATA_W-1:0] SEC_WR_MASK = 8'hff;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

    // Primary enable register fields.
    localparam int unsigned PRI_GATE_BIT = 7;
    localparam int unsigned PRI_T2_BIT = 5;
    localparam int unsigned PRI_S1_BIT = 4;
    localparam int unsigned PRI_T1_BIT = 3;
    localparam int unsigned PRI_X1_BIT = 2;
    localparam int unsigned PRI_T0_BIT = 1;
    localparam int unsigned PRI_X0_BIT = 0;
    localparam int unsigned PRI_SRC_N = 6;

    // Secondary enable register fields.
    localparam int unsigned SEC_PWM_BIT = 7;
    localparam int unsigned SEC_I2C_BIT = 6;
    localparam int unsigned SEC_S2_BIT = 5;
    localparam int unsigned SEC_SPI_BIT = 4;
    localparam int unsigned SEC_ADTK_BIT = 3;
    localparam int unsigned SEC_XLV_BIT = 2;
    localparam int unsigned SEC_P1_BIT = 1;
    localparam int unsigned SEC_T3_BIT = 0;

    // Request vector: primary bits 5..0 then secondary bits 7..0.
    localparam int unsigned SRC_N = 14;
    localparam int unsigned SRC_SEC_BASE = PRI_SRC_N;
    localparam int unsigned SRC_X0 = PRI_X0_BIT;
    localparam int unsigned SRC_T0 = PRI_T0_BIT;
    localparam int unsigned SRC_X1 = PRI_X1_BIT;
    localparam int unsigned SRC_T1 = PRI_T1_BIT;
    localparam int unsigned SRC_S1 = PRI_S1_BIT;
    localparam int unsigned SRC_T2 = PRI_T2_BIT;
    localparam int unsigned SRC_T3 = SRC_SEC_BASE + SEC_T3_BIT;
    localparam int unsigned SRC_XLV = SRC_SEC_BASE + SEC_XLV_BIT;
    localparam int unsigned SRC_SPI = SRC_SEC_BASE + SEC_SPI_BIT;
    localparam int unsigned SRC_S2 = SRC_SEC_BASE + SEC_S2_BIT;
    localparam int unsigned SRC_I2C = SRC_SEC_BASE + SEC_I2C_BIT;
    localparam int unsigned SRC_PWM = SRC_SEC_BASE + SEC_PWM_BIT;
    localparam logic [SRC_N-1:0] SRC_NONE = 14'h0000;

    // External wake pins: pin 0, pin 1, pins 2 to 9.
    localparam int unsigned PIN_N = 10;
    localparam int unsigned PIN_GRP_LO = 2;

    // Wake status layout.
    localparam int unsigned WK_N = 4;
    localparam int unsigned WK_X0 = 0;
    localparam int unsigned WK_X1 = 1;
    localparam int unsigned WK_XLV = 2;
    localparam int unsigned WK_T3 = 3;
    localparam logic [WK_N-1:0] WK_NONE = 4'h0;

endpackage : iebk_pkg

`default_nettype wire

// ---- hw/iebk_sync.sv ----
// Two-flop synchroniser for the external wake pins.
// Assumes the pins are asynchronous to CLOCK; one bit per pin.
`timescale 1ns/100ps
`default_nettype none

module iebk_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins and synchronised copy
    input wire logic [iebk_pkg::PIN_N-1:0] pin_raw,
    output logic [iebk_pkg::PIN_N-1:0] pin_sync
);
    import iebk_pkg::*;

    // Pins idle high, so reset loads ones to avoid a false wake.
    for (genvar i = 0; i < PIN_N; i++) begin : g_bit
        logic meta_r;
        logic hold_r;
        always_ff @(posedge clk) begin
            if (rst) begin
                meta_r <= 1'b1;
                hold_r <= 1'b1;
            end else begin
                meta_r <= pin_raw[i];
                hold_r <= meta_r;
            end
        end
        assign pin_sync[i] = hold_r;
    end

endmodule // iebk_sync

`default_nettype wire

// ---- hw/iebk_gate.sv ----
// Per-source request gate: a request passes when the global gate and
// its own enable are set. Assumes requests come from CLOCK-domain logic.
`timescale 1ns/100ps
`default_nettype none

module iebk_gate (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Enables
    input wire logic gate,
    input wire logic [iebk_pkg::SRC_N-1:0] en,
    // Requests in and forwarded
    input wire logic [iebk_pkg::SRC_N-1:0] req,
    output logic [iebk_pkg::SRC_N-1:0] fwd
);
    import iebk_pkg::*;

    for (genvar i = 0; i < SRC_N; i++) begin : g_src
        logic fwd_r;
        always_ff @(posedge clk) begin
            if (rst) begin
                fwd_r <= 1'b0;
            end else begin
                fwd_r <= gate & en[i] & req[i]; // see R1, R2
            end
        end
        assign fwd[i] = fwd_r;
    end

endmodule // iebk_gate

`default_nettype wire

// ---- hw/iebk_top.sv ----
// Interrupt enable bank: primary and secondary enable registers, request
// gating toward the CPU sequencer, and pin wake-up with sticky status.
// Assumes requests are CLOCK-domain levels and wake pins are asynchronous.
//
// Operation
// R1 - With the global gate set, each source follows its own enable bit.
// R2 - With the global gate clear, no request reaches the CPU; WAKE_REQ and WAKE_IRQ ignore the gate.
// R3 - Timer 2 request forwarded only while its enable bit is set.
// R4 - Primary bit 4 enables the first serial port interrupt.
// R5 - Primary bit 3 enables the timer 1 interrupt.
// R6 - Primary bit 2 enables external pin 1 interrupt and its wake-up.
// R7 - Primary bit 1 enables the timer 0 interrupt.
// R8 - Primary bit 0 enables external pin 0 interrupt and its wake-up.
// R9 - Secondary bit 7 enables the shared pulse group interrupt.
// R10 - Secondary bit 6 enables the two-wire interrupt, master or slave.
// R11 - Secondary bit 5 enables the second serial port interrupt.
// R12 - Secondary bit 4 enables the four-wire interrupt.
// R13 - After reset all enable bits read zero.
// R14 - Secondary bit 2 enables pins 2 to 9, their wake, low-voltage.
// R15 - Secondary bits 0, 1, 3: timer 3 plus wake, port change, converter.
`timescale 1ns/100ps
`default_nettype none

module iebk_top (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // Register port
    input wire logic [iebk_pkg::ADDR_W-1:0] ADDR,
    input wire logic [iebk_pkg::DATA_W-1:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [iebk_pkg::DATA_W-1:0] RD_DATA,
    // Interrupt requests from peripherals and toward the sequencer
    input wire logic [iebk_pkg::SRC_N-1:0] REQ_IN,
    output logic [iebk_pkg::SRC_N-1:0] IRQ_FWD,
    // External wake pins, active low
    input wire logic [iebk_pkg::PIN_N-1:0] EXT_PIN_N,
    // Wake-up request and wake event interrupt
    output logic WAKE_REQ,
    output logic WAKE_IRQ
);
    import iebk_pkg::*;

    logic [DATA_W-1:0] pri_en_r;
    logic [DATA_W-1:0] sec_en_r;
    logic [WK_N-1:0] wake_stat_r;
    logic [WK_N-1:0] wake_mask_r;
    logic [DATA_W-1:0] rd_data_r;
    logic wake_req_r;
    logic wake_irq_r;
    logic [PIN_N-1:0] pin_s;
    logic [SRC_N-1:0] src_en;
    logic [WK_N-1:0] wake_hit;
    logic [WK_N-1:0] wake_clr;
    logic global_irq_gate;
    logic timer_two_irq_en;
    logic serial_one_irq_en;
    logic timer_one_irq_en;
    logic ext_pin_one_irq_en;
    logic timer_zero_irq_en;
    logic ext_pin_zero_irq_en;
    logic pulse_group_irq_en;
    logic two_wire_irq_en;
    logic serial_two_irq_en;
    logic four_wire_irq_en;
    logic converter_touch_irq_en;
    logic ext_pins_lowvolt_irq_en;
    logic port_one_change_irq_en;
    logic timer_three_irq_en;
    logic wr_pri;
    logic wr_sec;
    logic wr_wstat;
    logic wr_wmask;

    assign wr_pri = WR_EN && (ADDR == PRI_EN_ADDR);
    assign wr_sec = WR_EN && (ADDR == SEC_EN_ADDR);
    assign wr_wstat = WR_EN && (ADDR == WAKE_STAT_ADDR);
    assign wr_wmask = WR_EN && (ADDR == WAKE_MASK_ADDR);

    // Bit 6 of the primary register has no function and is not stored.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            pri_en_r <= REG_RST; // see R13
        end else if (wr_pri) begin
            pri_en_r <= WR_DATA & PRI_WR_MASK;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            sec_en_r <= REG_RST; // see R13
        end else if (wr_sec) begin
            sec_en_r <= WR_DATA & SEC_WR_MASK;
        end
    end

    assign global_irq_gate = pri_en_r[PRI_GATE_BIT]; // see R1, R2
    assign timer_two_irq_en = pri_en_r[PRI_T2_BIT]; // see R3
    assign serial_one_irq_en = pri_en_r[PRI_S1_BIT]; // see R4
    assign timer_one_irq_en = pri_en_r[PRI_T1_BIT]; // see R5
    assign ext_pin_one_irq_en = pri_en_r[PRI_X1_BIT]; // see R6
    assign timer_zero_irq_en = pri_en_r[PRI_T0_BIT]; // see R7
    assign ext_pin_zero_irq_en = pri_en_r[PRI_X0_BIT]; // see R8
    assign pulse_group_irq_en = sec_en_r[SEC_PWM_BIT]; // see R9
    assign two_wire_irq_en = sec_en_r[SEC_I2C_BIT]; // see R10
    assign serial_two_irq_en = sec_en_r[SEC_S2_BIT]; // see R11
    assign four_wire_irq_en = sec_en_r[SEC_SPI_BIT]; // see R12
    assign converter_touch_irq_en = sec_en_r[SEC_ADTK_BIT]; // see R15
    assign ext_pins_lowvolt_irq_en = sec_en_r[SEC_XLV_BIT]; // see R14
    assign port_one_change_irq_en = sec_en_r[SEC_P1_BIT]; // see R15
    assign timer_three_irq_en = sec_en_r[SEC_T3_BIT]; // see R15

    assign src_en = {sec_en_r, pri_en_r[PRI_SRC_N-1:0]};

    iebk_gate u_gate (
        .clk(CLOCK),
        .rst(SYS_RST),
        .gate(global_irq_gate),
        .en(src_en),
        .req(REQ_IN),
        .fwd(IRQ_FWD)
    );

    iebk_sync u_sync (
        .clk(CLOCK),
        .rst(SYS_RST),
        .pin_raw(EXT_PIN_N),
        .pin_sync(pin_s)
    );

    // Wake-up ignores the global gate: a sleeping core must still be
    // woken even while software has masked interrupts globally.
    assign wake_hit[WK_X0] = ext_pin_zero_irq_en & ~pin_s[0]; // see R8
    assign wake_hit[WK_X1] = ext_pin_one_irq_en & ~pin_s[1]; // see R6
    assign wake_hit[WK_XLV] = ext_pins_lowvolt_irq_en &
        ~(&pin_s[PIN_N-1:PIN_GRP_LO]); // see R14
    assign wake_hit[WK_T3] = timer_three_irq_en & REQ_IN[SRC_T3]; // see R15

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            wake_req_r <= 1'b0;
        end else begin
            wake_req_r <= |wake_hit;
        end
    end

    assign wake_clr = wr_wstat ? WR_DATA[WK_N-1:0] : WK_NONE;

    // A wake event in the clearing cycle survives the clear.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            wake_stat_r <= WK_NONE;
        end else begin
            wake_stat_r <= (wake_stat_r & ~wake_clr) | wake_hit;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            wake_mask_r <= WK_NONE;
        end else if (wr_wmask) begin
            wake_mask_r <= WR_DATA[WK_N-1:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            wake_irq_r <= 1'b0;
        end else begin
            wake_irq_r <= |(wake_stat_r & wake_mask_r);
        end
    end

    // Read data stand for one cycle only; idle cycles read zero.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            rd_data_r <= READ_IDLE;
        end else if (RD_EN) begin
            case (ADDR)
                PRI_EN_ADDR: rd_data_r <= pri_en_r;
                SEC_EN_ADDR: rd_data_r <= sec_en_r;
                WAKE_STAT_ADDR: rd_data_r <= DATA_W'(wake_stat_r);
                WAKE_MASK_ADDR: rd_data_r <= DATA_W'(wake_mask_r);
                default: rd_data_r <= READ_IDLE;
            endcase
        end else begin
            rd_data_r <= READ_IDLE;
        end
    end

    assign RD_DATA = rd_data_r;
    assign WAKE_REQ = wake_req_r;
    assign WAKE_IRQ = wake_irq_r;

    chk_global_pass: assert property ( // see R1
        @(posedge CLOCK) disable iff (SYS_RST)
        global_irq_gate |=> IRQ_FWD == $past(src_en & REQ_IN))
        else $error("enabled request not forwarded as gated");

    chk_global_block: assert property ( // see R2
        @(posedge CLOCK) disable iff (SYS_RST)
        !global_irq_gate |=> IRQ_FWD == SRC_NONE)
        else $error("request passed with global gate clear");

    chk_timer_two: assert property ( // see R3
        @(posedge CLOCK) disable iff (SYS_RST)
        !timer_two_irq_en |=> !IRQ_FWD[SRC_T2])
        else $error("timer 2 request passed while disabled");

    chk_serial_one: assert property ( // see R4
        @(posedge CLOCK) disable iff (SYS_RST)
        global_irq_gate && REQ_IN[SRC_S1] ##0 serial_one_irq_en
        |=> IRQ_FWD[SRC_S1])
        else $error("serial one request lost");

    chk_serial_one_off: assert property ( // see R4
        @(posedge CLOCK) disable iff (SYS_RST)
        !serial_one_irq_en |=> !IRQ_FWD[SRC_S1])
        else $error("serial one request passed while disabled");

    chk_timer_one: assert property ( // see R5
        @(posedge CLOCK) disable iff (SYS_RST)
        $rose(IRQ_FWD[SRC_T1]) |-> $past(timer_one_irq_en))
        else $error("timer 1 forwarded while disabled");

    chk_pin_one_wake: assert property ( // see R6
        @(posedge CLOCK) disable iff (SYS_RST)
        ext_pin_one_irq_en && !pin_s[1]
        |=> wake_stat_r[WK_X1] && WAKE_REQ)
        else $error("pin 1 wake not raised");

    chk_pin_one_fwd: assert property ( // see R6
        @(posedge CLOCK) disable iff (SYS_RST)
        IRQ_FWD[SRC_X1] |-> $past(ext_pin_one_irq_en))
        else $error("pin 1 request forwarded while disabled");

    chk_timer_zero: assert property ( // see R7
        @(posedge CLOCK) disable iff (SYS_RST)
        IRQ_FWD[SRC_T0] |-> $past(timer_zero_irq_en && REQ_IN[SRC_T0]))
        else $error("timer 0 forwarded without cause");

    chk_pin_zero_wake: assert property ( // see R8
        @(posedge CLOCK) disable iff (SYS_RST)
        !ext_pin_zero_irq_en && !wr_wstat ##0 !wake_stat_r[WK_X0]
        |=> !wake_stat_r[WK_X0])
        else $error("pin 0 wake set while disabled");

    chk_pin_zero_fwd: assert property ( // see R8
        @(posedge CLOCK) disable iff (SYS_RST)
        IRQ_FWD[SRC_X0] |-> $past(ext_pin_zero_irq_en))
        else $error("pin 0 request forwarded while disabled");

    // Wake must not depend on the global gate, or a sleeping core with
    // interrupts masked globally could never be woken.
    chk_wake_ungated: assert property ( // see R8
        @(posedge CLOCK) disable iff (SYS_RST)
        ext_pin_zero_irq_en && !global_irq_gate && !pin_s[0] |=> WAKE_REQ)
        else $error("pin 0 wake blocked by global gate");

    chk_pulse_group: assert property ( // see R9
        @(posedge CLOCK) disable iff (SYS_RST)
        IRQ_FWD[SRC_PWM] |-> $past(pulse_group_irq_en))
        else $error("pulse group forwarded while disabled");

    chk_two_wire: assert property ( // see R10
        @(posedge CLOCK) disable iff (SYS_RST)
        IRQ_FWD[SRC_I2C] |-> $past(two_wire_irq_en))
        else $error("two-wire forwarded while disabled");

    chk_serial_two: assert property ( // see R11
        @(posedge CLOCK) disable iff (SYS_RST)
        IRQ_FWD[SRC_S2] |-> $past(serial_two_irq_en))
        else $error("serial two forwarded while disabled");

    chk_four_wire: assert property ( // see R12
        @(posedge CLOCK) disable iff (SYS_RST)
        IRQ_FWD[SRC_SPI] |-> $past(four_wire_irq_en))
        else $error("four-wire forwarded while disabled");

    chk_reset_clear: assert property ( // see R13
        @(posedge CLOCK)
        $past(SYS_RST) |-> pri_en_r == REG_RST && sec_en_r == REG_RST)
        else $error("enable bits not zero after reset");

    chk_pin_group: assert property ( // see R14
        @(posedge CLOCK) disable iff (SYS_RST)
        wake_hit[WK_XLV] |=> wake_stat_r[WK_XLV] ##1 wake_irq_r ||
        !$past(wake_mask_r[WK_XLV]))
        else $error("pin group wake not recorded");

    chk_pin_group_fwd: assert property ( // see R14
        @(posedge CLOCK) disable iff (SYS_RST)
        IRQ_FWD[SRC_XLV] |-> $past(ext_pins_lowvolt_irq_en))
        else $error("pin group request forwarded while disabled");

    chk_timer_three: assert property ( // see R15
        @(posedge CLOCK) disable iff (SYS_RST)
        timer_three_irq_en && REQ_IN[SRC_T3] |=> WAKE_REQ)
        else $error("timer 3 wake not raised");

    chk_timer_three_fwd: assert property ( // see R15
        @(posedge CLOCK) disable iff (SYS_RST)
        IRQ_FWD[SRC_T3] |-> $past(timer_three_irq_en))
        else $error("timer 3 request forwarded while disabled");

    chk_port_change: assert property ( // see R15
        @(posedge CLOCK) disable iff (SYS_RST)
        IRQ_FWD[SRC_SEC_BASE + SEC_P1_BIT]
        |-> $past(port_one_change_irq_en))
        else $error("port change request forwarded while disabled");

    chk_converter: assert property ( // see R15
        @(posedge CLOCK) disable iff (SYS_RST)
        IRQ_FWD[SRC_SEC_BASE + SEC_ADTK_BIT]
        |-> $past(converter_touch_irq_en))
        else $error("converter request forwarded while disabled");

    chk_set_wins: assert property ( // see R6, R8, R14, R15
        @(posedge CLOCK) disable iff (SYS_RST)
        wake_hit != WK_NONE
        |=> (wake_stat_r & $past(wake_hit)) == $past(wake_hit))
        else $error("wake event lost to a status clear");

    chk_wake_idle: assert property ( // see R6, R8, R14, R15
        @(posedge CLOCK) disable iff (SYS_RST)
        wake_hit == WK_NONE |=> !WAKE_REQ)
        else $error("wake request raised without a wake source");

    chk_wake_irq_on: assert property ( // see R6, R8
        @(posedge CLOCK) disable iff (SYS_RST)
        (wake_stat_r & wake_mask_r) != WK_NONE |=> WAKE_IRQ)
        else $error("unmasked wake status gave no interrupt");

    chk_wake_irq_off: assert property ( // see R6, R8
        @(posedge CLOCK) disable iff (SYS_RST)
        (wake_stat_r & wake_mask_r) == WK_NONE |=> !WAKE_IRQ)
        else $error("wake interrupt raised with nothing unmasked");

    chk_read_once: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        RD_EN && ADDR == PRI_EN_ADDR ##1 !RD_EN
        |-> RD_DATA == $past(pri_en_r) ##1 RD_DATA == READ_IDLE)
        else $error("primary read data wrong or held");

    chk_read_idle: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        !RD_EN |=> RD_DATA == READ_IDLE)
        else $error("read data not idle after a cycle without read");

    cov_forward: cover property (@(posedge CLOCK) disable iff (SYS_RST)
        global_irq_gate ##1 IRQ_FWD != SRC_NONE);

    cov_blocked: cover property (@(posedge CLOCK) disable iff (SYS_RST)
        !global_irq_gate && (src_en & REQ_IN) != SRC_NONE);

    cov_wake_irq: cover property (@(posedge CLOCK) disable iff (SYS_RST)
        $rose(WAKE_IRQ));

    cov_clear_race: cover property (@(posedge CLOCK) disable iff (SYS_RST)
        wr_wstat && (wake_clr & wake_hit) != WK_NONE);

endmodule // iebk_top

`default_nettype wire

// ---- test/iebk_periph_model.sv ----
// Behavioural peripheral request sources and external wake pins that
// face the enable bank. Assumes the bench names the wanted pattern.
`timescale 1ns/100ps
`default_nettype none

module iebk_periph_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wanted pattern and how many edges it is held back before it appears
    input wire logic [iebk_pkg::SRC_N-1:0] req_want,
    input wire logic [iebk_pkg::PIN_N-1:0] pin_low_want,
    input wire logic [3:0] lag,
    // Levels toward the bank
    output logic [iebk_pkg::SRC_N-1:0] req_out,
    output logic [iebk_pkg::PIN_N-1:0] pin_n_out
);
    import iebk_pkg::*;

    logic [3:0] wait_r;

    // A slow source is modelled by holding the old level for lag edges,
    // so the bank never sees a change earlier than a real peripheral.
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_r <= 4'h0;
            req_out <= SRC_NONE;
            pin_n_out <= '1;
        end else if ({req_want, ~pin_low_want} == {req_out, pin_n_out}) begin
            wait_r <= 4'h0;
        end else if (wait_r >= lag) begin
            wait_r <= 4'h0;
            req_out <= req_want;
            pin_n_out <= ~pin_low_want;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule // iebk_periph_model

`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the interrupt enable bank: register access,
// request gating per source and pin or timer wake-up with sticky status.
// Assumes the peripheral model drives requests and pins.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import iebk_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [DATA_W-1:0] rd_data;
    logic [SRC_N-1:0] req_in;
    logic [SRC_N-1:0] irq_fwd;
    logic [SRC_N-1:0] req_want = '0;
    logic [PIN_N-1:0] pin_n;
    logic [PIN_N-1:0] pin_low_want = '0;
    logic [3:0] lag = 4'h0;
    logic wake_req;
    logic wake_irq;
    int n_fail = 0;
    int tests_run = 0;
    int src_tab[4] = '{SRC_X0, SRC_X1, SRC_XLV, SRC_T3};
    int pin_tab[4] = '{0, 1, 5, -1};

    always #5 clk = ~clk;

    iebk_top DUT (
        .CLOCK(clk), .SYS_RST(rst), .ADDR(addr), .WR_DATA(wdata),
        .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
        .REQ_IN(req_in), .IRQ_FWD(irq_fwd), .EXT_PIN_N(pin_n),
        .WAKE_REQ(wake_req), .WAKE_IRQ(wake_irq)
    );

    iebk_periph_model PERIPH (
        .clk(clk), .rst(rst), .req_want(req_want),
        .pin_low_want(pin_low_want), .lag(lag),
        .req_out(req_in), .pin_n_out(pin_n)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe edge.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 check({8'h00, rd_data}, {8'h00, exp});
    endtask

    task automatic set_en(input logic [SRC_N-1:0] en, input logic gate);
        reg_wr(PRI_EN_ADDR, {gate, 1'b0, en[5:0]});
        reg_wr(SEC_EN_ADDR, en[13:6]);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic stim(input int k, input logic on);
        @(posedge clk);
        if (pin_tab[k] >= 0)
            pin_low_want[pin_tab[k]] <= on;
        else
            req_want[SRC_T3] <= on;
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #100us;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        check({2'b00, irq_fwd}, 16'h0000);
        check({14'h0000, wake_req, wake_irq}, 16'h0000);
        rd_chk(PRI_EN_ADDR, 8'h00);
        rd_chk(SEC_EN_ADDR, 8'h00);
        rd_chk(WAKE_STAT_ADDR, 8'h00);
        rd_chk(WAKE_MASK_ADDR, 8'h00);
        $display("test reset values done");

        reg_wr(PRI_EN_ADDR, 8'hff);
        reg_wr(SEC_EN_ADDR, 8'hff);
        reg_wr(8'h55, 8'hff);
        rd_chk(PRI_EN_ADDR, 8'hbf);
        rd_chk(SEC_EN_ADDR, 8'hff);
        rd_chk(8'h55, 8'h00);
        $display("test register access done");

        // Every source alone, at varied source delay; all requests raised.
        for (int i = 0; i < SRC_N; i++) begin
            set_en(14'h0001 << i, 1'b1);
            lag <= 4'(i % 4);
            req_want <= '1;
            cyc(8);
            check({2'b00, irq_fwd}, 16'h0001 << i);
            req_want <= '0;
            cyc(8);
            check({2'b00, irq_fwd}, 16'h0000);
        end
        lag <= 4'h0;
        set_en('1, 1'b0);
        req_want <= '1;
        cyc(6);
        check({2'b00, irq_fwd}, 16'h0000);
        set_en('1, 1'b1);
        cyc(3);
        check({2'b00, irq_fwd}, 16'h3fff);
        req_want <= '0;
        $display("test request gating done");

        // Pin 0, pin 1, pin group and timer 3 wake, disabled then enabled.
        for (int k = 0; k < 4; k++) begin
            set_en('0, 1'b0);
            stim(k, 1'b1);
            cyc(8);
            check({15'h0000, wake_req}, 16'h0000);
            stim(k, 1'b0);
            cyc(8);
            reg_wr(WAKE_STAT_ADDR, 8'h0f);
            reg_wr(WAKE_MASK_ADDR, 8'h00);
            set_en(14'h0001 << src_tab[k], 1'b0);
            stim(k, 1'b1);
            cyc(8);
            check({15'h0000, wake_req}, 16'h0001);
            rd_chk(WAKE_STAT_ADDR, 8'h01 << k);
            check({15'h0000, wake_irq}, 16'h0000);
            reg_wr(WAKE_MASK_ADDR, 8'h01 << k);
            cyc(3);
            check({15'h0000, wake_irq}, 16'h0001);
            stim(k, 1'b0);
            cyc(8);
            check({15'h0000, wake_req}, 16'h0000);
            reg_wr(WAKE_STAT_ADDR, 8'h01 << k);
            cyc(3);
            check({15'h0000, wake_irq}, 16'h0000);
            rd_chk(WAKE_STAT_ADDR, 8'h00);
        end
        $display("test wake paths done");
        tally_and_finish();
    end
endmodule // tb_top

`default_nettype wire
